// file: mbt_pkg.sv
package mbt_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] OFS_BUS_TIMING = 4'h0;
    localparam logic [3:0] OFS_MEM_CFG = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // Values after reset
    localparam logic [31:0] BUS_TIMING_RST = 32'hffffffff;
    localparam logic [31:0] MEM_CFG_RST = 32'hffffffff;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // Field positions in the bus-timing word
    localparam int S1_LEN_LSB = 20;
    localparam int S1_LEN_W = 3;
    localparam int S0_LEN_LSB = 16;
    localparam int S0_LEN_W = 4;
    localparam int S0_LEAD_LSB = 14;
    localparam int S0_LEAD_W = 2;
    localparam int S0_TRAIL_LSB = 11;
    localparam int S0_TRAIL_W = 3;
    localparam int S0_RECOV_LSB = 18;
    localparam int S0_RECOV_W = 2;

    // Bit positions in the memory configuration word
    localparam int CFG_NON_DRAM_BIT = 21;
    localparam int CFG_RECOV_BIT = 8;

    // Address bits that select a space
    localparam int SPACE_MSB = 31;
    localparam int SPACE_LSB = 30;
    localparam logic [1:0] SPACE0_CODE = 2'h0;
    localparam logic [1:0] SPACE1_CODE = 2'h1;

    // Cycle counts
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] RECOV_EXTRA = 5'h03;
    localparam logic [4:0] DRAM_STROBE_LEN = 5'h01;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_RECOV,
        PH_LEAD,
        PH_STROBE,
        PH_TRAIL
    } mbt_phase_t;

    // Length in cycles of each phase of one bus cycle; zero skips recov, lead or trail
    typedef struct packed {
        logic [4:0] recov;
        logic [4:0] lead;
        logic [4:0] strobe;
        logic [4:0] trail;
    } mbt_timing_t;

endpackage

// file: mbt_timing_decode.sv
`timescale 1ns/100ps
module mbt_timing_decode import mbt_pkg::*; (
    input wire logic [31:0] i_timing_word,
    input wire logic [31:0] i_config_word,
    input wire logic i_space0,
    output mbt_timing_t o_timing
);

    wire logic non_dram = i_config_word[CFG_NON_DRAM_BIT];
    wire logic slow_recov = i_config_word[CFG_RECOV_BIT];
    wire logic [4:0] s1_len =
        {2'h0, i_timing_word[S1_LEN_LSB +: S1_LEN_W]} + CNT_ONE;
    wire logic [4:0] s0_len =
        {1'h0, i_timing_word[S0_LEN_LSB +: S0_LEN_W]} + CNT_ONE;
    wire logic [4:0] s0_lead =
        {3'h0, i_timing_word[S0_LEAD_LSB +: S0_LEAD_W]};
    wire logic [4:0] s0_trail =
        {2'h0, i_timing_word[S0_TRAIL_LSB +: S0_TRAIL_W]};
    wire logic [4:0] recov_code =
        {3'h0, i_timing_word[S0_RECOV_LSB +: S0_RECOV_W]};
    wire logic [4:0] recov_len =
        recov_code + (slow_recov ? RECOV_EXTRA : CNT_ONE);

    // Space1: only the strobe length applies
    // Space0: setup, strobe and hold, or precharge then strobe on DRAM
    assign o_timing.recov = (i_space0 && !non_dram) ? recov_len : CNT_ZERO;
    assign o_timing.lead = (i_space0 && non_dram) ? s0_lead : CNT_ZERO;
    assign o_timing.trail = (i_space0 && non_dram) ? s0_trail : CNT_ZERO;
    assign o_timing.strobe = !i_space0 ? s1_len :
        (non_dram ? s0_len : DRAM_STROBE_LEN);

endmodule

// file: mbt_phase_counter.sv
`timescale 1ns/100ps
module mbt_phase_counter import mbt_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_en,
    input wire logic i_load,
    input wire logic [4:0] i_load_val,
    output logic [4:0] o_count,
    output logic o_zero
);

    wire logic [4:0] next_count = i_load ? i_load_val :
        (o_count == CNT_ZERO ? CNT_ZERO : o_count - CNT_ONE);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count <= CNT_ZERO;
        end else if (i_en) begin
            o_count <= next_count;
        end
    end

    assign o_zero = (o_count == CNT_ZERO);

endmodule

// file: mbt_bus_timing.sv
// The address map and strobed register access were decided locally.
`timescale 1ns/100ps
module mbt_bus_timing import mbt_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    input wire logic i_req_valid,
    input wire logic [31:0] i_req_addr,
    output logic o_busy,
    output logic o_req_done,
    output logic o_req_refused,
    output logic o_space0,
    output logic o_space1,
    output logic o_precharge,
    output logic o_lead,
    output logic o_strobe,
    output logic o_trail
);

    logic [31:0] bus_timing_word;
    logic [31:0] memory_config_word;
    mbt_phase_t phase;
    mbt_timing_t cur_tim;
    mbt_timing_t new_tim;
    logic [4:0] count;
    logic count_zero;

    function automatic mbt_phase_t phase_after(mbt_phase_t cur,
                                               mbt_timing_t t);
        phase_after = PH_IDLE;
        case (cur)
            PH_IDLE: begin
                if (t.recov != CNT_ZERO) begin
                    phase_after = PH_RECOV;
                end else if (t.lead != CNT_ZERO) begin
                    phase_after = PH_LEAD;
                end else begin
                    phase_after = PH_STROBE;
                end
            end
            PH_RECOV: begin
                phase_after = (t.lead != CNT_ZERO) ? PH_LEAD : PH_STROBE;
            end
            PH_LEAD: begin
                phase_after = PH_STROBE;
            end
            PH_STROBE: begin
                phase_after = (t.trail != CNT_ZERO) ? PH_TRAIL : PH_IDLE;
            end
            default: begin
                phase_after = PH_IDLE;
            end
        endcase
    endfunction

    function automatic logic [4:0] phase_load(mbt_phase_t ph,
                                              mbt_timing_t t);
        phase_load = CNT_ZERO;
        case (ph)
            PH_RECOV: begin
                phase_load = t.recov - CNT_ONE;
            end
            PH_LEAD: begin
                phase_load = t.lead - CNT_ONE;
            end
            PH_STROBE: begin
                phase_load = t.strobe - CNT_ONE;
            end
            PH_TRAIL: begin
                phase_load = t.trail - CNT_ONE;
            end
            default: begin
                phase_load = CNT_ZERO;
            end
        endcase
    endfunction

    // Register port decode
    wire logic wr_timing = i_reg_wr && (i_reg_addr == OFS_BUS_TIMING);
    wire logic wr_config = i_reg_wr && (i_reg_addr == OFS_MEM_CFG);
    wire logic [31:0] status_word =
        {26'h0, phase, o_space1, o_space0, o_busy};
    wire logic [31:0] read_sel =
        (i_reg_addr == OFS_MEM_CFG) ? memory_config_word :
        (i_reg_addr == OFS_STATUS) ? status_word : READ_ZERO;
    wire logic [31:0] next_rdata = i_reg_rd ? read_sel : READ_ZERO;

    // space decode from top address bits
    wire logic [1:0] req_space = i_req_addr[SPACE_MSB:SPACE_LSB];
    wire logic req_is_s0 = (req_space == SPACE0_CODE);
    wire logic req_is_s1 = (req_space == SPACE1_CODE);
    wire logic idle = (phase == PH_IDLE);
    wire logic take = idle && i_req_valid && (req_is_s0 || req_is_s1);
    wire logic refuse = idle && i_req_valid && !(req_is_s0 || req_is_s1);

    mbt_timing_decode u_decode (
        .i_timing_word(bus_timing_word),
        .i_config_word(memory_config_word),
        .i_space0(req_is_s0),
        .o_timing(new_tim)
    );

    // Sequencing of setup, precharge, strobe and hold phases
    wire logic phase_end = !idle && count_zero;
    wire mbt_phase_t next_phase = take ? phase_after(PH_IDLE, new_tim) :
        (phase_end ? phase_after(phase, cur_tim) : phase);
    wire logic cnt_load = take || phase_end;
    wire logic [4:0] cnt_val =
        phase_load(next_phase, take ? new_tim : cur_tim);
    wire logic next_done = phase_end && (next_phase == PH_IDLE);
    wire logic next_space0 = take ? req_is_s0 : (o_space0 && !next_done);
    wire logic next_space1 = take ? req_is_s1 : (o_space1 && !next_done);

    mbt_phase_counter u_counter (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_en(i_clk_en),
        .i_load(cnt_load),
        .i_load_val(cnt_val),
        .o_count(count),
        .o_zero(count_zero)
    );

    // both words reset to all ones
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bus_timing_word <= BUS_TIMING_RST;
            memory_config_word <= MEM_CFG_RST;
            o_reg_rdata <= READ_ZERO;
        end else if (i_clk_en) begin
            if (wr_timing) begin
                bus_timing_word <= i_reg_wdata;
            end
            if (wr_config) begin
                memory_config_word <= i_reg_wdata;
            end
            o_reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_tim <= '0;
        end else if (i_clk_en && take) begin
            cur_tim <= new_tim;
        end
    end

    // phase outputs follow the sequencer state
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            phase <= PH_IDLE;
            o_busy <= 1'b0;
            o_req_done <= 1'b0;
            o_req_refused <= 1'b0;
            o_space0 <= 1'b0;
            o_space1 <= 1'b0;
            o_precharge <= 1'b0;
            o_lead <= 1'b0;
            o_strobe <= 1'b0;
            o_trail <= 1'b0;
        end else if (i_clk_en) begin
            phase <= next_phase;
            o_busy <= (next_phase != PH_IDLE);
            o_req_done <= next_done;
            o_req_refused <= refuse;
            o_space0 <= next_space0;
            o_space1 <= next_space1;
            o_precharge <= (next_phase == PH_RECOV);
            o_lead <= (next_phase == PH_LEAD);
            o_strobe <= (next_phase == PH_STROBE);
            o_trail <= (next_phase == PH_TRAIL);
        end
    end

    // Checking helpers: captured words and phase run lengths
    logic [31:0] cap_word;
    logic [31:0] cap_cfg;
    logic [4:0] strobe_run;
    logic [4:0] lead_run;
    logic [4:0] trail_run;
    logic [4:0] recov_run;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cap_word <= READ_ZERO;
            cap_cfg <= READ_ZERO;
            strobe_run <= CNT_ZERO;
            lead_run <= CNT_ZERO;
            trail_run <= CNT_ZERO;
            recov_run <= CNT_ZERO;
        end else if (i_clk_en) begin
            if (take) begin
                cap_word <= bus_timing_word;
                cap_cfg <= memory_config_word;
            end
            strobe_run <= o_strobe ? strobe_run + CNT_ONE : CNT_ZERO;
            lead_run <= o_lead ? lead_run + CNT_ONE : CNT_ZERO;
            trail_run <= o_trail ? trail_run + CNT_ONE : CNT_ZERO;
            recov_run <= o_precharge ? recov_run + CNT_ONE : CNT_ZERO;
        end
    end

    wire logic cap_non_dram = cap_cfg[CFG_NON_DRAM_BIT];

    a_space1_strobe_len: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        ($fell(o_strobe) && $past(o_space1)) |->
        strobe_run == {2'h0, cap_word[S1_LEN_LSB +: S1_LEN_W]} + CNT_ONE)
        else $error("space1 strobe length wrong");

    a_space0_strobe_len: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        ($fell(o_strobe) && $past(o_space0) && cap_non_dram) |->
        strobe_run == {1'h0, cap_word[S0_LEN_LSB +: S0_LEN_W]} + CNT_ONE)
        else $error("space0 strobe length wrong");

    a_space0_lead_len: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        $fell(o_lead) |->
        (o_strobe && lead_run ==
         {3'h0, cap_word[S0_LEAD_LSB +: S0_LEAD_W]}))
        else $error("space0 setup length wrong");

    a_trail_follows: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        ($fell(o_strobe) && $past(o_space0) && cap_non_dram &&
         cap_word[S0_TRAIL_LSB +: S0_TRAIL_W] != 3'h0) |-> o_trail)
        else $error("hold phase missing after strobe");

    a_trail_len: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        $fell(o_trail) |-> (o_req_done && trail_run ==
         {2'h0, cap_word[S0_TRAIL_LSB +: S0_TRAIL_W]}))
        else $error("space0 hold length wrong");

    a_recov_len: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        $fell(o_precharge) |-> recov_run ==
        {3'h0, cap_word[S0_RECOV_LSB +: S0_RECOV_W]} +
        (cap_cfg[CFG_RECOV_BIT] ? RECOV_EXTRA : CNT_ONE))
        else $error("precharge length wrong");

    a_timing_unreadable: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        (i_reg_rd && i_reg_addr == OFS_BUS_TIMING) |=>
        o_reg_rdata == READ_ZERO)
        else $error("timing word read back nonzero");

    a_space0_select: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        (idle && i_req_valid) |=>
        (o_space0 == ($past(req_space) == SPACE0_CODE)))
        else $error("space0 chosen with top bits set");

    a_space1_phases: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        o_space1 |-> !(o_precharge || o_lead || o_trail))
        else $error("space1 access has extra phases");

    a_lead_non_dram: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        (o_lead || o_trail) |-> (o_space0 && cap_non_dram))
        else $error("setup or hold outside non-DRAM space0");

    a_precharge_dram: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        o_precharge |-> (o_space0 && !cap_non_dram))
        else $error("precharge outside DRAM space0");

    a_dram_strobe_len: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        ($fell(o_strobe) && $past(o_space0) && !cap_non_dram) |->
        strobe_run == DRAM_STROBE_LEN)
        else $error("DRAM strobe length wrong");

    a_reset_words: assert property (
        @(posedge i_ref_clk)
        ($past(i_rst) && !i_rst) |->
        (bus_timing_word == BUS_TIMING_RST &&
         memory_config_word == MEM_CFG_RST))
        else $error("words not all ones after reset");

    a_space_onehot: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        (o_busy == (o_space0 || o_space1)) && !(o_space0 && o_space1))
        else $error("space flags disagree with busy");

    a_refused_space: assert property (
        @(posedge i_ref_clk) disable iff (i_rst || !i_clk_en)
        o_req_refused |-> (!o_busy && $past(req_space) != SPACE0_CODE &&
         $past(req_space) != SPACE1_CODE))
        else $error("request refused inside space0 or space1");

endmodule

// file: mbt_mem_model.sv
`timescale 1ns/100ps
// Memory on the far side: measures how long each phase of an access lasts
module mbt_mem_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_busy,
    input wire logic i_precharge,
    input wire logic i_lead,
    input wire logic i_strobe,
    input wire logic i_trail,
    output logic [4:0] o_recov_len,
    output logic [4:0] o_lead_len,
    output logic [4:0] o_strobe_len,
    output logic [4:0] o_trail_len
);
    logic busy_q;
    wire logic start = i_busy && !busy_q;
    // Counts restart with each new access and hold once it ends
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            o_recov_len <= 5'h00;
            o_lead_len <= 5'h00;
            o_strobe_len <= 5'h00;
            o_trail_len <= 5'h00;
        end else begin
            busy_q <= i_busy;
            o_recov_len <= (start ? 5'h00 : o_recov_len) + {4'h0, i_precharge};
            o_lead_len <= (start ? 5'h00 : o_lead_len) + {4'h0, i_lead};
            o_strobe_len <= (start ? 5'h00 : o_strobe_len) + {4'h0, i_strobe};
            o_trail_len <= (start ? 5'h00 : o_trail_len) + {4'h0, i_trail};
        end
    end
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top import mbt_pkg::*;;
    typedef struct {
        logic [31:0] cfg, tim, addr;
        logic [4:0] r, l, s, t;
    } mbt_row_t;
    logic i_ref_clk = 1'b0, i_rst = 1'b1;
    logic [3:0] i_reg_addr = 4'h0;
    logic [31:0] i_reg_wdata = 32'h0, i_req_addr = 32'h0, rdata;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_req_valid = 1'b0;
    logic i_clk_en = 1'b1;
    logic [31:0] o_reg_rdata;
    logic o_busy, o_req_done, o_req_refused, o_space0, o_space1;
    logic o_precharge, o_lead, o_strobe, o_trail;
    logic [4:0] rl, ll, sl, tl;
    int error_cnt = 0, comparisons = 0;
    mbt_row_t rows [9] = '{
        '{32'h0, 32'h0, 32'h40000000, 5'h0, 5'h0, 5'h1, 5'h0},
        '{32'h0, 32'h00700000, 32'h7fffffff, 5'h0, 5'h0, 5'h8, 5'h0},
        '{32'h00200000, 32'h000f0000, 32'h0, 5'h0, 5'h0, 5'h10, 5'h0},
        '{32'h00200000, 32'h0000f800, 32'h0, 5'h0, 5'h3, 5'h1, 5'h7},
        '{32'h00200000, 32'h00024800, 32'h3ffffffc, 5'h0, 5'h1, 5'h3, 5'h1},
        '{32'h0, 32'h0, 32'h0, 5'h1, 5'h0, 5'h1, 5'h0},
        '{32'h0, 32'h000c0000, 32'h0, 5'h4, 5'h0, 5'h1, 5'h0},
        '{32'h00000100, 32'h0, 32'h0, 5'h3, 5'h0, 5'h1, 5'h0},
        '{32'h00000100, 32'h000c0000, 32'h0, 5'h6, 5'h0, 5'h1, 5'h0}};

    always #12.5 i_ref_clk = ~i_ref_clk;

    mbt_bus_timing dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_req_valid(i_req_valid), .i_req_addr(i_req_addr), .o_busy(o_busy),
        .o_req_done(o_req_done), .o_req_refused(o_req_refused),
        .o_space0(o_space0), .o_space1(o_space1), .o_precharge(o_precharge),
        .o_lead(o_lead), .o_strobe(o_strobe), .o_trail(o_trail));
    mbt_mem_model mem (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_busy(o_busy), .i_precharge(o_precharge), .i_lead(o_lead),
        .i_strobe(o_strobe), .i_trail(o_trail), .o_recov_len(rl),
        .o_lead_len(ll), .o_strobe_len(sl), .o_trail_len(tl));

    task automatic chk(input logic [31:0] got, exp, input string m);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_ref_clk);
        rdata = o_reg_rdata;
    endtask
    task automatic req(input logic [31:0] a);
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req_addr <= a;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
        @(negedge i_ref_clk);
    endtask
    // Counts cycles from the first phase cycle up to the done pulse
    task automatic wait_done(output int n);
        n = 1;
        while (o_req_done !== 1'b1 && n < 40) begin
            @(negedge i_ref_clk);
            n++;
        end
    endtask
    task automatic run_req(input logic [31:0] a, input logic [4:0] r, l, s, t);
        int n;
        req(a);
        chk(o_space0, a[31:30] == 2'h0, "space0 select");
        chk(o_space1, a[31:30] == 2'h1, "space1 select");
        wait_done(n);
        chk(32'(n), r + l + s + t + 1, "access length");
        chk({rl, ll, sl, tl}, {r, l, s, t}, "phases");
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(25ns * 5000);
        error_cnt++;
        final_report();
    end

    initial begin
        int n;
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        foreach (rows[i]) begin
            wr(OFS_MEM_CFG, rows[i].cfg);
            wr(OFS_BUS_TIMING, rows[i].tim);
            run_req(rows[i].addr, rows[i].r, rows[i].l, rows[i].s, rows[i].t);
        end
        // Back to back: second request given in the done cycle
        wr(OFS_BUS_TIMING, 32'h0);
        req(32'h40000000);
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        @(negedge i_ref_clk);
        chk(o_req_done, 1'b1, "done cycle");
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
        @(negedge i_ref_clk);
        chk({o_busy, o_strobe, o_space1}, 32'h7, "second access");
        wait_done(n);
        chk(32'(n), 32'h2, "second length");
        // Request during a running access is ignored
        wr(OFS_MEM_CFG, 32'h00200000);
        wr(OFS_BUS_TIMING, 32'h000f0000);
        req(32'h0);
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req_addr <= 32'h80000000;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
        @(negedge i_ref_clk);
        chk(o_req_refused, 1'b0, "refused while busy");
        chk(o_space0, 1'b1, "space kept");
        wait_done(n);
        chk(sl, 5'h10, "strobe kept");
        req(32'hc0000000);
        chk({o_req_refused, o_busy}, 32'h2, "outside space");
        rd(OFS_MEM_CFG);
        chk(rdata, 32'h00200000, "config readback");
        rd(OFS_BUS_TIMING);
        chk(rdata, READ_ZERO, "timing write-only");
        rd(4'hc);
        chk(rdata, READ_ZERO, "unmapped read");
        // Clock enable low freezes the register port
        @(posedge i_ref_clk);
        i_clk_en <= 1'b0;
        wr(OFS_MEM_CFG, 32'h0);
        i_clk_en <= 1'b1;
        rd(OFS_MEM_CFG);
        chk(rdata, 32'h00200000, "frozen write");
        // Reset in mid-run restores all-ones words
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        rd(OFS_MEM_CFG);
        chk(rdata, MEM_CFG_RST, "config reset");
        run_req(32'h0, 5'h0, 5'h3, 5'h10, 5'h7);
        final_report();
    end
endmodule
